// ===== usib_pkg.sv
// shared constants, types and helpers of the uart status and baud block
package usib_pkg;
    localparam logic [31:0] ADDR_DATA = 32'hffff0700;
    localparam logic [31:0] ADDR_IEN = 32'hffff0704;
    localparam logic [31:0] ADDR_IID = 32'hffff0708;
    localparam logic [31:0] ADDR_FMT = 32'hffff070c;
    localparam logic [31:0] ADDR_LSR = 32'hffff0714;
    localparam logic [31:0] ADDR_MSR = 32'hffff0718;
    localparam logic [31:0] ADDR_IDIV = 32'hffff0720;
    localparam logic [31:0] ADDR_FDIV = 32'hffff072c;
    localparam logic [7:0] LSR_RST = 8'h60;
    localparam logic [7:0] IID_RST = 8'h01;
    localparam logic [3:0] IEN_RST = 4'h0;
    localparam logic [15:0] FDIV_RST = 16'h0000;
    localparam logic [15:0] IDIV_RST = 16'h0001;
    localparam logic [15:0] FDIV_MASK = 16'h9fff;
    localparam int LSR_TX_ALL_EMPTY = 6;
    localparam int LSR_TX_HOLDING_EMPTY = 5;
    localparam int LSR_BI = 4;
    localparam int LSR_FE = 3;
    localparam int LSR_PE = 2;
    localparam int LSR_OE = 1;
    localparam int LSR_DR = 0;
    localparam int MSR_CTS = 4;
    localparam int MSR_CTS_CHANGED = 0;
    localparam int IEN_MODEM = 3;
    localparam int IEN_LINE = 2;
    localparam int IEN_TX = 1;
    localparam int IEN_RX = 0;
    localparam int FDIV_EN = 15;
    localparam int FBM_LO = 11;
    localparam int FBN_HI = 10;
    localparam logic [1:0] IID_LINE = 2'h3;
    localparam logic [1:0] IID_RXF = 2'h2;
    localparam logic [1:0] IID_TXE = 2'h1;
    localparam logic [1:0] IID_MODEM = 2'h0;
    localparam logic [2:0] FBM_ZERO_M = 3'h4;
    localparam logic [13:0] FRAC_ONE = 14'h0800;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [7:0] BRK_TICKS = 8'hc0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] wlen;
        logic stop2;
        logic par_en;
        logic par_even;
    } usib_fmt_t;

    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic perr;
        logic ferr;
        logic brk;
    } usib_rx_evt_t;

    function automatic logic [7:0] usib_mask(input logic [1:0] wlen);
        usib_mask = 8'hff >> (2'h3 - wlen);
    endfunction

    // parity bit that goes with the masked data under the given format
    function automatic logic usib_par(input logic [7:0] d, input usib_fmt_t f);
        usib_par = (^(d & usib_mask(f.wlen))) ^ ~f.par_even;
    endfunction
endpackage

// ===== usib_baud.sv
// oversample tick generator, integer or fractional divisor
`timescale 1ns/1ps
module usib_baud
    import usib_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic [15:0] idiv_i, // integer divisor
    input wire logic frac_en_i, // fractional mode
    input wire logic [1:0] fbm_i, // multiplier field
    input wire logic [10:0] fbn_i, // numerator field
    output logic tick_o // 16x oversample pulse
);
    logic [31:0] acc_ff;
    logic [31:0] nxt_acc;
    logic tick_ff;
    wire [2:0] mult = (fbm_i == 2'h0) ? FBM_ZERO_M : {1'b0, fbm_i}; // see R16
    wire [13:0] scale = frac_en_i ? {mult, fbn_i} : FRAC_ONE; // see R15 see R17
    wire [15:0] div = (idiv_i == 16'h0) ? 16'h1 : idiv_i;
    // bit time = 32*D*(M+N/2048) clocks, 16 ticks per bit
    wire [31:0] thresh = {1'b0, div * {16'h0, scale}, 1'b0}; // see R19
    wire [31:0] sum = acc_ff + {18'h0, FRAC_ONE};
    wire hit = sum >= thresh;

    assign nxt_acc = hit ? sum - thresh : sum;
    assign tick_o = tick_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            tick_ff <= hit;
        end
    end
endmodule // usib_baud

// ===== usib_rx.sv
// serial receiver: framing, parity and break detection
`timescale 1ns/1ps
module usib_rx
    import usib_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic tick_i, // 16x oversample pulse
    input wire logic rxd_i, // synchronised serial input
    input wire usib_fmt_t fmt_i, // frame format
    output usib_rx_evt_t evt_o // one-cycle receive events
);
    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} usib_rxst_t;
    usib_rxst_t st_ff;
    logic [3:0] sub_ff;
    logic [2:0] idx_ff;
    logic [7:0] sh_ff;
    logic perr_ff;
    logic [7:0] low_ff;
    usib_rx_evt_t evt_ff;
    wire mid = tick_i && sub_ff == OVS_LAST;

    assign evt_o = evt_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= S_IDLE;
            sub_ff <= 4'h0;
            idx_ff <= 3'h0;
            sh_ff <= 8'h0;
            perr_ff <= 1'b0;
            low_ff <= 8'h0;
            evt_ff <= '0;
        end else begin
            evt_ff <= '0;
            if (tick_i)
                sub_ff <= sub_ff + 4'h1;
            // line held low past a whole longest frame
            if (rxd_i)
                low_ff <= 8'h0;
            else if (tick_i && low_ff <= BRK_TICKS)
                low_ff <= low_ff + 8'h1;
            if (tick_i && low_ff == BRK_TICKS)
                evt_ff.brk <= 1'b1; // see R3
            unique case (st_ff)
                S_IDLE: begin
                    sub_ff <= 4'h0;
                    if (!rxd_i && low_ff == 8'h0)
                        st_ff <= S_START;
                end
                S_START: if (tick_i && sub_ff == OVS_MID) begin
                    sub_ff <= 4'h0;
                    idx_ff <= 3'h0;
                    perr_ff <= 1'b0;
                    st_ff <= rxd_i ? S_IDLE : S_DATA;
                end
                S_DATA: if (mid) begin
                    sh_ff <= {rxd_i, sh_ff[7:1]};
                    idx_ff <= idx_ff + 3'h1;
                    if (idx_ff == {1'b0, fmt_i.wlen} + 3'h4)
                        st_ff <= fmt_i.par_en ? S_PAR : S_STOP;
                end
                S_PAR: if (mid) begin
                    perr_ff <= rxd_i != usib_par(sh_ff >> (2'h3 - fmt_i.wlen), fmt_i); // see R5
                    st_ff <= S_STOP;
                end
                S_STOP: if (mid) begin
                    // only the first stop bit is checked
                    evt_ff.done <= 1'b1;
                    evt_ff.data <= (sh_ff >> (2'h3 - fmt_i.wlen)) & usib_mask(fmt_i.wlen);
                    evt_ff.perr <= perr_ff;
                    evt_ff.ferr <= !rxd_i; // see R4 see R18
                    st_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule // usib_rx

// ===== usib_uart_status.sv
// uart status, interrupt identification and baud control with axi4-lite slave
// Functional notes
// R1: tx_all_empty set when holding and shifter idle
// R2: tx_holding_empty set once holding register emptied
// R3: break_detected set on overlong low receive line
// R4: framing_error set on bad stop bit
// R5: parity_error set on wrong received parity
// R6: overrun set when unread data is overwritten
// R7: rx_data_available set on receive, read clears
// R8: line status read-only, resets to 0x60
// R9: modem status shows cts, delta cleared on read
// R10: modem enable raises irq on cts or delta
// R11: line enable raises irq on overrun/parity/framing
// R12: tx enable raises irq while holding empty
// R13: rx enable raises irq when receive buffer full
// R14: source register reports highest pending, read clears tx
// R15: frac_baud_enable selects fractional generator
// R16: frac_multiplier zero means multiplier four
// R17: frac_numerator is eleven-bit fraction over 2048
// R18: receiver checks the first stop bit only
// R19: baud is clock/(32*D*(M+N/2048))
// R20: single irq high while any enabled source pends
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module usib_uart_status
    import usib_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset, active high
    input wire logic [31:0] s_axi_awaddr_i, // write address
    input wire logic s_axi_awvalid_i, // write address valid
    output logic s_axi_awready_o, // write address ready
    input wire logic [31:0] s_axi_wdata_i, // write data
    input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
    input wire logic s_axi_wvalid_i, // write data valid
    output logic s_axi_wready_o, // write data ready
    output logic [1:0] s_axi_bresp_o, // write response
    output logic s_axi_bvalid_o, // write response valid
    input wire logic s_axi_bready_i, // write response ready
    input wire logic [31:0] s_axi_araddr_i, // read address
    input wire logic s_axi_arvalid_i, // read address valid
    output logic s_axi_arready_o, // read address ready
    output logic [31:0] s_axi_rdata_o, // read data
    output logic [1:0] s_axi_rresp_o, // read response
    output logic s_axi_rvalid_o, // read data valid
    input wire logic s_axi_rready_i, // read data ready
    input wire logic rxd_i, // serial receive pin
    input wire logic cts_i, // clear-to-send pin
    output logic txd_o, // serial transmit pin
    output logic irq_o // uart interrupt request
);
    function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
        hit = a[31:2] == base[31:2];
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // start bit, data lsb first, optional parity, then ones for stop bits
    function automatic logic [11:0] frame(input logic [7:0] d, input usib_fmt_t f);
        logic [11:0] v;
        logic [3:0] n;
        v = 12'hffe;
        n = {2'h0, f.wlen} + 4'h5;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < n)
                v[i+1] = d[i];
        end
        if (f.par_en)
            v[n+4'h1] = usib_par(d, f);
        frame = v;
    endfunction

    // bus side registers
    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // software controls
    logic [3:0] ien_ff;
    logic [15:0] fdiv_ff;
    logic [15:0] idiv_ff;
    usib_fmt_t fmt_ff;

    // transmit path
    logic [7:0] thr_ff;
    logic tx_holding_empty_ff;
    logic tx_busy_ff;
    logic [11:0] tx_sh_ff;
    logic [3:0] tx_left_ff;
    logic [3:0] tx_sub_ff;
    logic txd_ff;
    logic tx_pend_ff;

    // receive and modem state
    logic [7:0] rx_data_ff;
    logic dr_ff;
    logic oe_ff;
    logic pe_ff;
    logic fe_ff;
    logic bi_ff;
    logic rxd_s1_ff;
    logic rxd_s2_ff;
    logic cts_s1_ff;
    logic cts_s2_ff;
    logic cts_prev_ff;
    logic cts_changed_ff;
    logic irq_ff;

    logic tick;
    usib_rx_evt_t rx_evt;

    usib_baud u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .idiv_i(idiv_ff),
        .frac_en_i(fdiv_ff[FDIV_EN]),
        .fbm_i(fdiv_ff[FBM_LO+1:FBM_LO]),
        .fbn_i(fdiv_ff[FBN_HI:0]),
        .tick_o(tick)
    );

    usib_rx u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .rxd_i(rxd_s2_ff),
        .fmt_i(fmt_ff),
        .evt_o(rx_evt)
    );

    // bus decode
    wire aw_take = s_axi_awvalid_i & awready_ff;
    wire w_take = s_axi_wvalid_i & wready_ff;
    wire wr_do = aw_held_ff & w_held_ff & !bvalid_ff;
    wire ar_take = s_axi_arvalid_i & arready_ff;
    wire wr_ien = wr_do & hit(awaddr_ff, ADDR_IEN);
    wire wr_fmt = wr_do & hit(awaddr_ff, ADDR_FMT);
    wire wr_idiv = wr_do & hit(awaddr_ff, ADDR_IDIV);
    wire wr_fdiv = wr_do & hit(awaddr_ff, ADDR_FDIV);
    wire wr_thr = wr_do & hit(awaddr_ff, ADDR_DATA) & wstrb_ff[0];
    wire wr_ok = hit(awaddr_ff, ADDR_IEN) | hit(awaddr_ff, ADDR_FMT) |
                 hit(awaddr_ff, ADDR_IDIV) | hit(awaddr_ff, ADDR_FDIV) |
                 hit(awaddr_ff, ADDR_DATA);
    wire rd_rx = ar_take & hit(s_axi_araddr_i, ADDR_DATA);
    wire rd_lsr = ar_take & hit(s_axi_araddr_i, ADDR_LSR);
    wire rd_msr = ar_take & hit(s_axi_araddr_i, ADDR_MSR);
    wire rd_iid = ar_take & hit(s_axi_araddr_i, ADDR_IID);

    // status words
    wire tx_all_empty = tx_holding_empty_ff & !tx_busy_ff; // see R1
    wire [7:0] lsr = {1'b0, tx_all_empty, tx_holding_empty_ff, bi_ff, fe_ff, pe_ff, oe_ff, dr_ff}; // see R8
    wire [7:0] msr = {3'h0, cts_s2_ff, 3'h0, cts_changed_ff}; // see R9

    // pending sources and identification
    wire line_p = ien_ff[IEN_LINE] & (oe_ff | pe_ff | fe_ff); // see R11
    wire rx_p = ien_ff[IEN_RX] & dr_ff; // see R13
    wire tx_p = ien_ff[IEN_TX] & tx_holding_empty_ff & tx_pend_ff; // see R12
    wire mdm_p = ien_ff[IEN_MODEM] & (cts_s2_ff | cts_changed_ff); // see R10
    wire any_p = line_p | rx_p | tx_p | mdm_p;
    wire [1:0] iid_src = line_p ? IID_LINE : rx_p ? IID_RXF : tx_p ? IID_TXE : IID_MODEM;
    wire [7:0] iid = any_p ? {5'h0, iid_src, 1'b0} : IID_RST; // see R14
    wire iid_tx = !line_p & !rx_p & tx_p;

    wire rd_ok = hit(s_axi_araddr_i, ADDR_DATA) | hit(s_axi_araddr_i, ADDR_IEN) |
                 hit(s_axi_araddr_i, ADDR_IID) | hit(s_axi_araddr_i, ADDR_FMT) |
                 hit(s_axi_araddr_i, ADDR_LSR) | hit(s_axi_araddr_i, ADDR_MSR) |
                 hit(s_axi_araddr_i, ADDR_IDIV) | hit(s_axi_araddr_i, ADDR_FDIV);
    wire [31:0] rd_word =
        hit(s_axi_araddr_i, ADDR_DATA) ? {24'h0, rx_data_ff} :
        hit(s_axi_araddr_i, ADDR_IEN) ? {28'h0, ien_ff} :
        hit(s_axi_araddr_i, ADDR_IID) ? {24'h0, iid} :
        hit(s_axi_araddr_i, ADDR_FMT) ? {27'h0, fmt_ff} :
        hit(s_axi_araddr_i, ADDR_LSR) ? {24'h0, lsr} :
        hit(s_axi_araddr_i, ADDR_MSR) ? {24'h0, msr} :
        hit(s_axi_araddr_i, ADDR_IDIV) ? {16'h0, idiv_ff} :
        hit(s_axi_araddr_i, ADDR_FDIV) ? {16'h0, fdiv_ff} : 32'h0;

    // bus handshake next state
    wire nxt_aw_held = (aw_held_ff | aw_take) & !wr_do;
    wire nxt_w_held = (w_held_ff | w_take) & !wr_do;
    wire nxt_bvalid = wr_do | (bvalid_ff & !s_axi_bready_i);
    wire nxt_rvalid = ar_take | (rvalid_ff & !s_axi_rready_i);

    // transmitter next state
    wire tx_load = !tx_busy_ff & !tx_holding_empty_ff;
    wire tx_bit_end = tx_busy_ff & tick & (tx_sub_ff == OVS_LAST);
    wire [3:0] tx_len = {2'h0, fmt_ff.wlen} + 4'h7 + {3'h0, fmt_ff.par_en} +
                        {3'h0, fmt_ff.stop2};
    wire nxt_busy = tx_load | (tx_busy_ff & !(tx_bit_end & tx_left_ff == 4'h1));
    wire [11:0] nxt_sh = tx_load ? frame(thr_ff, fmt_ff) :
                         tx_bit_end ? {1'b1, tx_sh_ff[11:1]} : tx_sh_ff;
    // a write fills the holding reg, so it wins over the load
    wire nxt_tx_holding_empty = !wr_thr & (tx_holding_empty_ff | tx_load); // see R2
    wire cts_edge = cts_s2_ff != cts_prev_ff;

    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign txd_o = txd_ff;
    assign irq_o = irq_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 32'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= !nxt_aw_held & !nxt_bvalid;
            wready_ff <= !nxt_w_held & !nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            arready_ff <= !nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (aw_take)
                awaddr_ff <= s_axi_awaddr_i;
            if (w_take) begin
                wdata_ff <= s_axi_wdata_i;
                wstrb_ff <= s_axi_wstrb_i;
            end
            if (wr_do)
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien_ff <= IEN_RST;
            fdiv_ff <= FDIV_RST;
            idiv_ff <= IDIV_RST;
            fmt_ff <= '0;
            thr_ff <= 8'h0;
        end else begin
            if (wr_ien & wstrb_ff[0])
                ien_ff <= wdata_ff[3:0];
            if (wr_fmt & wstrb_ff[0])
                fmt_ff <= wdata_ff[4:0];
            if (wr_idiv)
                idiv_ff <= merge(idiv_ff, wdata_ff, wstrb_ff);
            if (wr_fdiv)
                fdiv_ff <= merge(fdiv_ff, wdata_ff, wstrb_ff) & FDIV_MASK; // see R15
            if (wr_thr)
                thr_ff <= wdata_ff[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_holding_empty_ff <= 1'b1;
            tx_busy_ff <= 1'b0;
            tx_sh_ff <= 12'hfff;
            tx_left_ff <= 4'h0;
            tx_sub_ff <= 4'h0;
            txd_ff <= 1'b1;
            tx_pend_ff <= 1'b1;
        end else begin
            tx_holding_empty_ff <= nxt_tx_holding_empty; // see R1
            tx_busy_ff <= nxt_busy;
            tx_sh_ff <= nxt_sh;
            txd_ff <= nxt_busy ? nxt_sh[0] : 1'b1;
            if (tx_load) begin
                tx_left_ff <= tx_len;
                tx_sub_ff <= 4'h0;
            end else if (tx_busy_ff & tick) begin
                tx_sub_ff <= tx_sub_ff + 4'h1;
                if (tx_bit_end)
                    tx_left_ff <= tx_left_ff - 4'h1;
            end
            // the empty event sets pending even in the cycle it would be cleared
            if (!tx_holding_empty_ff & nxt_tx_holding_empty)
                tx_pend_ff <= 1'b1; // see R12
            else if (wr_thr | (rd_iid & iid_tx))
                tx_pend_ff <= 1'b0; // see R14
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_data_ff <= 8'h0;
            dr_ff <= 1'b0;
            oe_ff <= 1'b0;
            pe_ff <= 1'b0;
            fe_ff <= 1'b0;
            bi_ff <= 1'b0;
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            cts_s1_ff <= 1'b0;
            cts_s2_ff <= 1'b0;
            cts_prev_ff <= 1'b0;
            cts_changed_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            rxd_s1_ff <= rxd_i;
            rxd_s2_ff <= rxd_s1_ff;
            cts_s1_ff <= cts_i;
            cts_s2_ff <= cts_s1_ff;
            cts_prev_ff <= cts_s2_ff;
            if (rx_evt.done)
                rx_data_ff <= rx_evt.data;
            dr_ff <= rx_evt.done | (dr_ff & !rd_rx); // see R7
            // status errors clear on a status read; a new event wins
            oe_ff <= (rx_evt.done & dr_ff & !rd_rx) | (oe_ff & !rd_lsr); // see R6
            pe_ff <= (rx_evt.done & rx_evt.perr) | (pe_ff & !rd_lsr); // see R5
            fe_ff <= (rx_evt.done & rx_evt.ferr) | (fe_ff & !rd_lsr); // see R4
            bi_ff <= rx_evt.brk | (bi_ff & !rd_lsr); // see R3
            cts_changed_ff <= cts_edge | (cts_changed_ff & !rd_msr); // see R9
            irq_ff <= any_p; // see R20
        end
    end
endmodule // usib_uart_status

// ===== usib_uart_status_monitor.sv
// bus and register-read checks for the uart status block
`timescale 1ns/1ps
module usib_uart_status_monitor
    import usib_pkg::*;
(
    input logic clk_i, // clock
    input logic rst_i, // sync reset
    input logic s_axi_awvalid_i, // aw valid
    input logic s_axi_awready_o, // aw ready
    input logic s_axi_wvalid_i, // w valid
    input logic s_axi_wready_o, // w ready
    input logic s_axi_bvalid_o, // b valid
    input logic s_axi_bready_i, // b ready
    input logic [31:0] s_axi_araddr_i, // ar address
    input logic s_axi_arvalid_i, // ar valid
    input logic s_axi_arready_o, // ar ready
    input logic [31:0] s_axi_rdata_o, // r data
    input logic [1:0] s_axi_rresp_o, // r resp
    input logic s_axi_rvalid_o, // r valid
    input logic s_axi_rready_i // r ready
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire ar_hit = s_axi_arvalid_i && s_axi_arready_o;
    wire aw_hit = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    wr_answer_a: assert property (aw_hit |-> ##[1:2] s_axi_bvalid_o)
        else $error("write not answered");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("bvalid dropped early");
    rd_answer_a: assert property (ar_hit |=> s_axi_rvalid_o)
        else $error("read not answered");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data moved");
    lsr_read_a: assert property (ar_hit && s_axi_araddr_i == ADDR_LSR |=>
        s_axi_rdata_o[31:7] == 25'h0) else $error("lsr high bits");
    msr_read_a: assert property (ar_hit && s_axi_araddr_i == ADDR_MSR |=>
        s_axi_rdata_o[31:5] == 27'h0 && s_axi_rdata_o[3:1] == 3'h0)
        else $error("msr reserved bits");
    iid_code_a: assert property (ar_hit && s_axi_araddr_i == ADDR_IID |=>
        s_axi_rdata_o[31:3] == 29'h0 && (!s_axi_rdata_o[0] || s_axi_rdata_o[2:1] == 2'h0))
        else $error("bad source code");
    bad_addr_a: assert property (ar_hit && s_axi_araddr_i == 32'hffff0710 |=>
        s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read");
endmodule // usib_uart_status_monitor
bind usib_uart_status usib_uart_status_monitor u_mon (.*);

// ===== usib_peer.sv
// remote serial sender model: drives the receive line and clear-to-send
`timescale 1ns/1ps
module usib_peer (
    input wire logic clk_i, // system clock
    output logic rxd_o = 1'h1, // line into the block, idles high
    output logic cts_o = 1'h0 // clear-to-send level
);
    task automatic put(input logic b, input int n);
        @(posedge clk_i);
        rxd_o <= b;
        repeat (n - 1) @(posedge clk_i);
    endtask
    // 8E1 frame; bad_p flips parity, bad_s drops stop
    task automatic send(input logic [7:0] d, input logic bad_p = 1'h0, input logic bad_s = 1'h0,
                        input int bt = 32);
        put(1'h0, bt);
        for (int i = 0; i < 8; i++) begin
            put(d[i], bt);
        end
        put(^d ^ bad_p, bt);
        put(~bad_s, bt);
        put(1'h1, bt);
    endtask
    task automatic hold_low(input int n);
        put(1'h0, n);
        put(1'h1, 32);
    endtask
    task automatic set_cts(input logic v);
        @(posedge clk_i);
        cts_o <= v;
    endtask
endmodule // usib_peer

// ===== usib_uart_status_test.sv
// self-checking bench for the uart status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end
module usib_uart_status_test
    import usib_pkg::*;
;
    logic clk_i = 1'h0, rst_i = 1'h1;
    logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic rxd_i, cts_i, txd_o, irq_o;
    int n_mismatch = 0, num_checks = 0;
    always #5 clk_i = ~clk_i;
    usib_uart_status u_dut (.*);
    usib_peer u_peer (.clk_i(clk_i), .rxd_o(rxd_i), .cts_o(cts_i));
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready_o === 1'h1) s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o === 1'h1) s_axi_wvalid_i <= 1'h0;
        end while (s_axi_bvalid_o !== 1'h1);
        s_axi_bready_i <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready_o === 1'h1) s_axi_arvalid_i <= 1'h0;
        end while (s_axi_rvalid_o !== 1'h1);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'h0;
    endtask
    task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e,
                      input logic [31:0] m = '1);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK(nm, e, d & m)
    endtask
    task automatic rl(input logic [31:0] e, input logic [31:0] m = '1);
        rc("lsr", ADDR_LSR, e, m);
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rc("ien", ADDR_IEN, 32'h0);
        rc("iid", ADDR_IID, 32'h1);
        rl(32'h60);
        rc("msr", ADDR_MSR, 32'h0);
        rc("fdiv", ADDR_FDIV, 32'h0);
        wr(ADDR_FDIV, 32'hffffffff);
        rc("fdiv", ADDR_FDIV, 32'h9fff);
        wr(ADDR_FDIV, 32'h0);
        wr(ADDR_LSR, 32'h0);
        rl(32'h60);
        rd(32'hffff0710, d, r);
        `CHK("bad resp", RESP_SLVERR, r)
    endtask
    task automatic t_tx();
        wr(ADDR_IEN, 32'h2);
        idle(2);
        `CHK("irq", 1'h1, irq_o)
        rc("iid", ADDR_IID, 32'h2);
        rc("iid", ADDR_IID, 32'h1);
        idle(2);
        `CHK("irq", 1'h0, irq_o)
        // second word lands while the first still shifts out
        wr(ADDR_DATA, 32'h55);
        wr(ADDR_DATA, 32'haa);
        rl(32'h0, 32'h60);
        idle(800);
        rl(32'h60);
        `CHK("txd", 1'h1, txd_o)
        rc("iid", ADDR_IID, 32'h2);
        wr(ADDR_IEN, 32'h0);
    endtask
    task automatic t_rx();
        logic [31:0] d;
        logic [1:0] r;
        wr(ADDR_FMT, 32'h1b);
        wr(ADDR_IEN, 32'h5);
        u_peer.send(8'ha5);
        idle(20);
        `CHK("irq", 1'h1, irq_o)
        rc("iid", ADDR_IID, 32'h4);
        rl(32'h61);
        rc("rx", ADDR_DATA, 32'ha5);
        rl(32'h60);
        u_peer.send(8'h3c);
        u_peer.send(8'hc3);
        idle(20);
        rc("iid", ADDR_IID, 32'h6);
        rl(32'h63);
        rc("rx", ADDR_DATA, 32'hc3);
        u_peer.send(8'h5a, 1'h1);
        idle(20);
        rl(32'h65);
        rl(32'h61);
        rc("rx", ADDR_DATA, 32'h5a);
        u_peer.send(8'h0f, 1'h0, 1'h1);
        idle(20);
        rl(32'h8, 32'he);
        rd(ADDR_DATA, d, r);
        u_peer.hold_low(500);
        idle(20);
        rl(32'h10, 32'h10);
        rl(32'h0, 32'h10);
        rd(ADDR_DATA, d, r);
        wr(ADDR_IEN, 32'h0);
    endtask
    task automatic t_modem();
        wr(ADDR_IEN, 32'h8);
        u_peer.set_cts(1'h1);
        idle(10);
        `CHK("irq", 1'h1, irq_o)
        rc("iid", ADDR_IID, 32'h0);
        rc("msr", ADDR_MSR, 32'h11);
        rc("msr", ADDR_MSR, 32'h10);
        u_peer.set_cts(1'h0);
        idle(10);
        rc("msr", ADDR_MSR, 32'h01);
        idle(2);
        `CHK("irq", 1'h0, irq_o)
        rc("iid", ADDR_IID, 32'h1);
    endtask
    task automatic t_frac();
        logic [31:0] fd [2] = '{32'h8000, 32'h8c00};
        int bt [2] = '{128, 48};
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_FDIV, fd[i]);
            u_peer.send(8'h96, 1'h0, 1'h0, bt[i]);
            idle(20);
            rl(32'h61);
            rc("rx", ADDR_DATA, 32'h96);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // run needs about 6k cycles
    initial begin
        #500us;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_tx();
        t_rx();
        t_modem();
        t_frac();
        tally_and_finish();
    end
endmodule // usib_uart_status_test
